// [align_pkg.sv]
// Constants and carrier types for the status-flag and sample-alignment block.
// Assumes one 200 MHz system clock standing in for the oscillator; FIFO storage lives outside.
// Function
// R1 - Watermark flag sets when entries equal watermark
// R2 - Watermark flag clears when entries drop below
// R3 - Status read clears watermark only below it
// R4 - Overrun flag sets on write past 96
// R5 - Status read clears overrun until new loss
// R6 - Activity sets after consecutive over-threshold measurements
// R7 - Any axis over threshold continues run
// R8 - Status read clears activity; re-sets next measurement
// R9 - Busy flag mirrors nonvolatile controller busy
// R10 - Interrupts blocked until busy flag clears
// R11 - Busy flag clears on read after idle
// R12 - Mode 00 samples at internal programmed rate
// R13 - Sample-ready pin high when sample available
// R14 - Mode 10 interpolates, 64x rate resolution
// R15 - Host keeps alignment pulses at most 4000/s
// R16 - Pulse to ready delay per rate setting
// R17 - Host drives 1.024 MHz clock and pulse
// R18 - External clock missing: no data, null outputs
// R19 - Host holds pulse four external clock cycles
// R20 - No pulse yet: run on internal rate
// R21 - Stay aligned to the most recent pulse
// R22 - Ready clears on data read or halfway
// R23 - Up to three samples lost after first pulse
// R24 - Alignment pulse synchronised before edge detection
package align_pkg;
  localparam int unsigned FIFO_DEPTH = 96;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned DATA_W = 20;
  localparam int unsigned AXES = 3;
  localparam int unsigned RATE_W = 4;
  localparam int unsigned TICK_W = 24;
  // Register offsets of this block's own port
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_XDATA = 8'h08;
  localparam logic [7:0] ADDR_ZDATA_END = 8'h10;
  localparam logic [7:0] ADDR_FIFO = 8'h11;
  localparam logic [7:0] ADDR_WATERMARK = 8'h29;
  localparam logic [7:0] ADDR_ACT_THR = 8'h25;
  localparam logic [7:0] ADDR_ACT_CNT = 8'h27;
  localparam logic [7:0] ADDR_RATE = 8'h28;
  localparam logic [7:0] ADDR_SYNC = 8'h2B;
  // Status bit positions
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_OVR = 2;
  localparam int unsigned ST_ACT = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_ALIGN = 2'h1;
  localparam logic [1:0] MODE_INTERP = 2'h2;
  localparam int unsigned INTERP_FACTOR = 64;
  localparam logic [7:0] WATERMARK_RST = 8'h60;
  localparam logic [RATE_W-1:0] RATE_MAX = 4'hA;
  // Clock-loss watchdog, in system cycles (a 1.024 MHz period is about 195)
  localparam logic [9:0] EXTERNAL_CLOCK_SELECT_TIMEOUT = 10'h3E8;
  // Internal sample period at rate setting 0, in system cycles
  localparam logic [TICK_W-1:0] BASE_PERIOD = 24'h0030D4;
  typedef struct packed {
    logic busy;
    logic activity;
    logic overrun;
    logic level;
  } status_s;
  typedef struct packed {
    logic [1:0] mode;
    logic external_clock_select;
  } sync_cfg_s;
  function automatic logic [TICK_W-1:0] period_of(input logic [RATE_W-1:0] r);
    // Internal sample period in system cycles: doubles per setting
    period_of = BASE_PERIOD << r;
  endfunction
  function automatic logic [12:0] interp_delay(input logic [RATE_W-1:0] r);
    case (r)
      4'h0: interp_delay = 13'h0008;
      4'h1: interp_delay = 13'h000A;
      4'h2: interp_delay = 13'h000E;
      4'h3: interp_delay = 13'h0016;
      4'h4: interp_delay = 13'h0026;
      4'h5: interp_delay = 13'h0046;
      4'h6: interp_delay = 13'h0086;
      4'h7: interp_delay = 13'h0106;
      4'h8: interp_delay = 13'h0407;
      4'h9: interp_delay = 13'h0806;
      default: interp_delay = 13'h1006;
    endcase
  endfunction
endpackage

// [pulse_sync.sv]
// Three-flop synchroniser with rising-edge output.
// Assumes an asynchronous input; second and third stages must agree.
`timescale 1ns/100ps
`default_nettype none
module pulse_sync (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic [2:0] sync_q;
  logic level_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], async_i};
    end
  end
  // Stage 0 is seen only by stage 1
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end
  assign level_o = level_q;
  assign rise_o = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q; // R24
endmodule
`default_nettype wire

// [activity_det.sv]
// Activity detector: counts consecutive measurements with any axis over threshold.
// Assumes one meas_i pulse per measurement with all axis magnitudes valid.
`timescale 1ns/100ps
`default_nettype none
module activity_det #(
  parameter int unsigned AXES = align_pkg::AXES,
  parameter int unsigned DATA_W = align_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic meas_i,
  input wire logic [AXES*DATA_W-1:0] mag_i,
  input wire logic [15:0] threshold_i,
  input wire logic [7:0] count_i,
  output logic hit_o
);
  logic [AXES-1:0] over;
  logic [7:0] run_q;
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      assign over[g] = mag_i[g*DATA_W +: DATA_W] > {threshold_i, 4'h0};
    end
  endgenerate
  // Any axis keeps the run alive, even if it moves between axes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 8'h00;
    end else if (meas_i) begin
      if (|over) begin // R7
        run_q <= (run_q == 8'hFF) ? run_q : run_q + 8'h01;
      end else begin
        run_q <= 8'h00;
      end
    end
  end
  // Nine bits so that a saturated run still reaches the count
  assign hit_o = meas_i && (|over) && (({1'b0, run_q} + 9'h001) >= {1'b0, count_i}); // R6
endmodule
`default_nettype wire

// [accel_status_and_sample_align.sv]
// Status flags and sample timing/alignment with sample-ready pin driver.
// Assumes FIFO counts, writes and nonvolatile busy come from same-clock logic.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module accel_status_and_sample_align #(
  parameter int unsigned CNT_W = align_pkg::CNT_W,
  parameter int unsigned FIFO_DEPTH = align_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [CNT_W-1:0] fifo_entries_i,
  input wire logic fifo_write_i,
  input wire logic nonvolatile_controller_busy_flag_i,
  input wire logic [align_pkg::AXES*align_pkg::DATA_W-1:0] mag_i,
  input wire logic secondary_irq_pin_i,
  input wire logic sample_ready_pin_i,
  output logic sample_ready_pin_o,
  output logic sample_ready_pin_oe_o,
  output logic sample_strobe_o,
  output logic irq_enable_o,
  output logic data_valid_o
);
  align_pkg::status_s status_q;
  align_pkg::sync_cfg_s cfg_q;
  logic [7:0] watermark_q, act_cnt_q, rdata_q;
  logic [15:0] act_thr_q;
  logic [align_pkg::RATE_W-1:0] rate_q;
  logic [align_pkg::TICK_W-1:0] tick_q;
  logic [12:0] dly_q;
  logic dly_run_q, ready_q, aligned_q, ext_alive_q, aligned_interp_q;
  logic [9:0] ext_wd_q;
  logic status_rd, data_rd, sample, act_hit, full_now;
  logic pulse_rise, ext_rise;
  logic [align_pkg::TICK_W-1:0] period;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_HOLD} fsm_e;
  fsm_e st_q;

  assign status_rd = rd_i && (addr_i == align_pkg::ADDR_STATUS);
  assign data_rd = rd_i && ((addr_i == align_pkg::ADDR_FIFO) ||
    ((addr_i >= align_pkg::ADDR_XDATA) && (addr_i <= align_pkg::ADDR_ZDATA_END)));
  assign period = align_pkg::period_of(rate_q);
  assign full_now = ({1'b0, fifo_entries_i} >= watermark_q[CNT_W:0]);

  // Pulse arrives on the ready pin while an alignment mode is selected
  pulse_sync u_sync_pulse (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(sample_ready_pin_i),
    .level_o(),
    .rise_o(pulse_rise)
  );
  pulse_sync u_sync_clk (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(secondary_irq_pin_i),
    .level_o(),
    .rise_o(ext_rise)
  );
  activity_det u_act (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .meas_i(sample),
    .mag_i(mag_i),
    .threshold_i(act_thr_q),
    .count_i(act_cnt_q),
    .hit_o(act_hit)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watermark_q <= align_pkg::WATERMARK_RST;
      act_thr_q <= 16'h0000;
      act_cnt_q <= 8'h00;
      rate_q <= 4'h0;
      cfg_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        align_pkg::ADDR_WATERMARK: watermark_q <= wdata_i;
        align_pkg::ADDR_ACT_THR: act_thr_q <= {wdata_i, 8'h00};
        align_pkg::ADDR_ACT_CNT: act_cnt_q <= wdata_i;
        align_pkg::ADDR_RATE: rate_q <= (wdata_i[3:0] > align_pkg::RATE_MAX) ? align_pkg::RATE_MAX : wdata_i[3:0];
        align_pkg::ADDR_SYNC: cfg_q <= {wdata_i[1:0], wdata_i[2]};
        default: ;
      endcase
    end
  end

  // Set wins over a same-cycle status read clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= '0;
    end else begin
      if (full_now && (fifo_entries_i == watermark_q[CNT_W-1:0])) begin
        status_q.level <= 1'b1; // R1
      end else if (!full_now) begin
        status_q.level <= 1'b0; // R2 R3
      end
      if (fifo_write_i && (fifo_entries_i == CNT_W'(FIFO_DEPTH))) begin
        status_q.overrun <= 1'b1; // R4
      end else if (status_rd) begin
        status_q.overrun <= 1'b0; // R5
      end
      if (act_hit) begin
        status_q.activity <= 1'b1; // R6
      end else if (status_rd) begin
        status_q.activity <= 1'b0; // R8
      end
      if (nonvolatile_controller_busy_flag_i) begin
        status_q.busy <= 1'b1; // R9
      end else if (status_rd) begin
        status_q.busy <= 1'b0; // R11
      end
    end
  end
  assign irq_enable_o = !status_q.busy; // R10

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        align_pkg::ADDR_STATUS: rdata_q <= {3'h0, status_q, 1'b0};
        align_pkg::ADDR_WATERMARK: rdata_q <= watermark_q;
        align_pkg::ADDR_ACT_THR: rdata_q <= act_thr_q[15:8];
        align_pkg::ADDR_ACT_CNT: rdata_q <= act_cnt_q;
        align_pkg::ADDR_RATE: rdata_q <= {4'h0, rate_q};
        align_pkg::ADDR_SYNC: rdata_q <= {5'h00, cfg_q.external_clock_select, cfg_q.mode};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // External clock watchdog: no edges means no processing
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_wd_q <= 10'h000;
      ext_alive_q <= 1'b0;
    end else if (ext_rise) begin
      ext_wd_q <= 10'h000;
      ext_alive_q <= 1'b1;
    end else if (ext_wd_q == align_pkg::EXTERNAL_CLOCK_SELECT_TIMEOUT) begin
      ext_alive_q <= 1'b0; // R18
    end else begin
      ext_wd_q <= ext_wd_q + 10'h001;
    end
  end
  assign data_valid_o = !cfg_q.external_clock_select || ext_alive_q; // R18

  // Sample timebase; a pulse in MODE_ALIGN re-phases it and alignment is kept after
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_q <= '0;
      aligned_q <= 1'b0;
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE: begin
          tick_q <= '0;
          st_q <= S_RUN;
        end
        S_RUN: begin
          if ((cfg_q.mode == align_pkg::MODE_ALIGN) && pulse_rise) begin
            tick_q <= '0; // R21
            aligned_q <= 1'b1;
          end else if (tick_q >= period - 1'b1) begin
            tick_q <= '0; // R12 R20
          end else begin
            tick_q <= tick_q + 1'b1;
          end
          if (!data_valid_o) begin
            st_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (data_valid_o) begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Interpolated mode: sample emerges a fixed delay after the pulse edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly_q <= 13'h0000;
      dly_run_q <= 1'b0;
    end else if ((cfg_q.mode == align_pkg::MODE_INTERP) && pulse_rise) begin
      dly_q <= align_pkg::interp_delay(rate_q) - 13'h0001; // R14 R16
      dly_run_q <= 1'b1;
    end else if (dly_run_q) begin
      if (dly_q == 13'h0000) begin
        dly_run_q <= 1'b0;
      end else begin
        dly_q <= dly_q - 13'h0001;
      end
    end
  end

  // Interpolated mode emits only on pulses; internal rate until the first
  assign sample = (st_q == S_RUN) && data_valid_o &&
    (((cfg_q.mode == align_pkg::MODE_INTERP) && aligned_interp_q) ? (dly_run_q && dly_q == 13'h0000)
     : ((cfg_q.mode == align_pkg::MODE_ALIGN) && pulse_rise) || (tick_q >= period - 1'b1));
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aligned_interp_q <= 1'b0;
    end else if (cfg_q.mode != align_pkg::MODE_INTERP) begin
      aligned_interp_q <= 1'b0;
    end else if (pulse_rise) begin
      aligned_interp_q <= 1'b1; // R20 R21
    end
  end
  assign sample_strobe_o = sample;

  // Ready pin: set on sample, cleared on data read or halfway to next
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_q <= 1'b0;
    end else if (sample) begin
      ready_q <= 1'b1; // R13
    end else if (data_rd || (tick_q == (period >> 1))) begin
      ready_q <= 1'b0; // R22
    end
  end
  // Pin turns input in alignment modes; first samples may be stale
  assign sample_ready_pin_oe_o = (cfg_q.mode == align_pkg::MODE_INTERNAL); // R23
  assign sample_ready_pin_o = ready_q && sample_ready_pin_oe_o;

  property p_ovr_set;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (fifo_write_i && fifo_entries_i == CNT_W'(FIFO_DEPTH)) |=> status_q.overrun;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set"); // R4
  property p_ovr_clr;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (status_rd && !(fifo_write_i && fifo_entries_i == CNT_W'(FIFO_DEPTH))) |=> !status_q.overrun;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared"); // R5
  property p_level_low;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !full_now |=> !status_q.level;
  endproperty
  a_level_low: assert property (p_level_low) else $error("level flag held below watermark"); // R2
  property p_level_keep;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (status_q.level && full_now) |=> status_q.level;
  endproperty
  a_level_keep: assert property (p_level_keep) else $error("level flag lost at watermark"); // R3
  property p_act;
    @(posedge clk_sys_i) disable iff (!arst_n_i) act_hit |=> status_q.activity;
  endproperty
  a_act: assert property (p_act) else $error("activity not set"); // R8
  property p_busy;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (status_q.busy && !status_rd) |=> status_q.busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy cleared without read"); // R11
  property p_irq;
    @(posedge clk_sys_i) disable iff (!arst_n_i) nonvolatile_controller_busy_flag_i |=> !irq_enable_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq enabled while busy"); // R10
  property p_ready;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (sample && cfg_q.mode == align_pkg::MODE_INTERNAL) |=> sample_ready_pin_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready pin not raised"); // R13
  property p_rdclr;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (data_rd && !sample) |=> !ready_q;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("ready not cleared by read"); // R22
  // Flag set, hold and clear paths, timebase wrap, interpolation, clock loss, ready clear and alignment
  property p_level_set;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ({1'b0, fifo_entries_i} == watermark_q[CNT_W:0]) |=> status_q.level;
  endproperty
  a_level_set: assert property (p_level_set) else $error("level flag not set at watermark"); // R1
  property p_ovr_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (!status_q.overrun && !(fifo_write_i && fifo_entries_i == CNT_W'(FIFO_DEPTH))) |=> !status_q.overrun;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun set without loss"); // R5
  property p_act_clr;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (status_rd && !act_hit) |=> !status_q.activity;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("activity not cleared by read"); // R8
  property p_act_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (status_q.activity && !status_rd) |=> status_q.activity;
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("activity lost without read"); // R8
  property p_busy_set;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      nonvolatile_controller_busy_flag_i |=> status_q.busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag not set"); // R9
  property p_tick_wrap;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_q == S_RUN && data_valid_o && cfg_q.mode == align_pkg::MODE_INTERNAL &&
       tick_q >= period - 1'b1) |-> sample;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("no sample at period end"); // R12
  property p_interp_load;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (cfg_q.mode == align_pkg::MODE_INTERP && pulse_rise && !wr_i) |=>
      (dly_run_q && dly_q == align_pkg::interp_delay(rate_q) - 13'h0001);
  endproperty
  a_interp_load: assert property (p_interp_load) else $error("delay not loaded on pulse"); // R16
  property p_interp_gap;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (cfg_q.mode == align_pkg::MODE_INTERP && aligned_interp_q && !(dly_run_q && dly_q == 13'h0000)) |-> !sample;
  endproperty
  a_interp_gap: assert property (p_interp_gap) else $error("interpolated sample off pulse"); // R14
  property p_no_clk;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (cfg_q.external_clock_select && !ext_alive_q) |-> (!data_valid_o && !sample);
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("sample without external clock"); // R18
  property p_align;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (cfg_q.mode == align_pkg::MODE_ALIGN && pulse_rise && st_q == S_RUN) |=> (tick_q == '0 && aligned_q);
  endproperty
  a_align: assert property (p_align) else $error("timebase not realigned"); // R21
  property p_half;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (tick_q == (period >> 1) && !sample) |=> !ready_q;
  endproperty
  a_half: assert property (p_half) else $error("ready not cleared halfway"); // R22
  property p_rise_once;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      pulse_rise |=> !pulse_rise;
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("pulse edge seen twice"); // R24
  c_ovr: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) status_q.overrun ##1 status_rd);
  c_interp: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    dly_run_q && dly_q == 13'h0000);
  c_align: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) aligned_q);
  c_busy_clr: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) status_q.busy ##1 !status_q.busy);
  c_act_set: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) act_hit);
endmodule
`default_nettype wire

// [host_model.sv]
// Host-side model: alignment pulse source and external sample clock.
// Assumes the bench puts sync_o on the ready pin only while the block releases it.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic external_clock_select_en_i,
  input wire logic interp_i,
  output logic external_clock_select_o,
  output logic sync_o
);
  realtime last_t = -1.0e9;
  initial begin
    external_clock_select_o = 1'b0;
    sync_o = 1'b0;
    // Clock stands still while not enabled, like a gated host timer
    forever begin
      #488.3;
      external_clock_select_o = external_clock_select_en_i ? ~external_clock_select_o : 1'b0;
    end
  end
  task automatic send_pulse();
    // Interpolation caps the pulse rate, so pulses are spaced out
    if (interp_i && ($realtime - last_t < 250000.0)) begin
      #(250000.0 - ($realtime - last_t));
    end
    last_t = $realtime;
    sync_o = 1'b1;
    #4000;
    sync_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the status flags and sample alignment block.
// Assumes the host model on the far side and default CNT_W and FIFO_DEPTH.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_i, arst_n_i, wr_i, rd_i, fifo_write_i, nonvolatile_controller_busy_flag_i;
  logic [7:0] addr_i, wdata_i, rdata_o, s;
  logic [align_pkg::CNT_W-1:0] fifo_entries_i;
  logic [align_pkg::AXES*align_pkg::DATA_W-1:0] mag_i;
  logic rdy_o, rdy_oe, strobe, irq_en, dvalid, external_clock_select, sync, ext_en, interp;
  wire logic rdy_wire;
  int n_errors, n_checks, n;
  realtime t0, t1;
  // The ready pin is shared: the host drives it only when the block lets go
  assign rdy_wire = rdy_oe ? rdy_o : sync;
  accel_status_and_sample_align accel_status_and_sample_align_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fifo_entries_i(fifo_entries_i),
    .fifo_write_i(fifo_write_i), .nonvolatile_controller_busy_flag_i(nonvolatile_controller_busy_flag_i), .mag_i(mag_i),
    .secondary_irq_pin_i(external_clock_select), .sample_ready_pin_i(rdy_wire),
    .sample_ready_pin_o(rdy_o), .sample_ready_pin_oe_o(rdy_oe),
    .sample_strobe_o(strobe), .irq_enable_o(irq_en), .data_valid_o(dvalid)
  );
  host_model host_model_inst (
    .external_clock_select_en_i(ext_en), .interp_i(interp), .external_clock_select_o(external_clock_select), .sync_o(sync)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic st(input int p, input logic e, input string what);
    rd(align_pkg::ADDR_STATUS, s);
    check({7'h0, s[p]}, {7'h0, e}, what);
  endtask
  task automatic fifo(input logic [align_pkg::CNT_W-1:0] v, input logic w);
    @(posedge clk_sys_i);
    fifo_entries_i <= v;
    fifo_write_i <= w;
    @(posedge clk_sys_i);
    fifo_write_i <= 1'b0;
  endtask
  task automatic wait_strobe(output int cycles);
    cycles = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      cycles++;
      if (cycles > 26000) begin
        $display("wrong value at %0t: no sample strobe", $time);
        n_errors++;
        report_and_stop();
      end
    end while (strobe !== 1'b1);
  endtask
  initial begin
    {arst_n_i, wr_i, rd_i, fifo_write_i, nonvolatile_controller_busy_flag_i, ext_en, interp} = '0;
    {addr_i, wdata_i, fifo_entries_i, mag_i} = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys_i);
    check({5'h0, rdy_oe, irq_en, dvalid}, 8'h07, "reset outputs");
    arst_n_i <= 1'b1;
    rd(align_pkg::ADDR_STATUS, s);
    check(s, 8'h00, "status after reset");
    rd(8'h3F, s);
    check(s, 8'h00, "unmapped read");
    $display("test reset done");
    wr(align_pkg::ADDR_WATERMARK, 8'h05);
    fifo(7'h04, 1'b0);
    st(align_pkg::ST_FULL, 1'b0, "level below");
    fifo(7'h05, 1'b0);
    st(align_pkg::ST_FULL, 1'b1, "level equal");
    fifo(7'h06, 1'b0);
    st(align_pkg::ST_FULL, 1'b1, "level kept by read");
    fifo(7'h04, 1'b0);
    st(align_pkg::ST_FULL, 1'b0, "level below again");
    fifo(7'h5F, 1'b1);
    st(align_pkg::ST_OVR, 1'b0, "write at 95");
    fifo(7'h60, 1'b1);
    st(align_pkg::ST_OVR, 1'b1, "write past 96");
    st(align_pkg::ST_OVR, 1'b0, "overrun read clear");
    fifo(7'h00, 1'b0);
    $display("test fifo flags done");
    @(posedge clk_sys_i);
    nonvolatile_controller_busy_flag_i <= 1'b1;
    st(align_pkg::ST_BUSY, 1'b1, "busy set");
    check({7'h0, irq_en}, 8'h00, "irq blocked");
    @(posedge clk_sys_i);
    nonvolatile_controller_busy_flag_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({7'h0, irq_en}, 8'h00, "irq blocked until read");
    st(align_pkg::ST_BUSY, 1'b1, "busy held until read");
    st(align_pkg::ST_BUSY, 1'b0, "busy cleared");
    check({7'h0, irq_en}, 8'h01, "irq released");
    $display("test busy done");
    wr(align_pkg::ADDR_ACT_THR, 8'h01);
    wr(align_pkg::ADDR_ACT_CNT, 8'h02);
    wait_strobe(n);
    @(posedge clk_sys_i);
    mag_i <= {40'h0, 20'h20000};
    wait_strobe(n);
    @(posedge clk_sys_i);
    mag_i <= {20'h0, 20'h20000, 20'h0};
    st(align_pkg::ST_ACT, 1'b0, "one measurement only");
    wait_strobe(n);
    t0 = $realtime;
    st(align_pkg::ST_ACT, 1'b1, "activity on axis shift");
    st(align_pkg::ST_ACT, 1'b0, "activity read clear");
    check({7'h0, rdy_o}, 8'h01, "ready after sample");
    rd(align_pkg::ADDR_XDATA, s);
    @(posedge clk_sys_i);
    #1;
    check({7'h0, rdy_o}, 8'h00, "ready cleared by data read");
    wait_strobe(n);
    t1 = $realtime;
    check_count(int'((t1 - t0) / 5.0), 12500, 12500, "internal period");
    st(align_pkg::ST_ACT, 1'b1, "activity set again");
    repeat (6200) @(posedge clk_sys_i);
    #1;
    check({7'h0, rdy_o}, 8'h01, "ready before halfway");
    repeat (100) @(posedge clk_sys_i);
    #1;
    check({7'h0, rdy_o}, 8'h00, "ready autoclear");
    @(posedge clk_sys_i);
    mag_i <= '0;
    $display("test activity and ready done");
    interp = 1'b1;
    wr(align_pkg::ADDR_SYNC, {6'h0, align_pkg::MODE_INTERP});
    wait_strobe(n);
    wait_strobe(n);
    check_count(n, 12500, 12500, "internal rate without pulse");
    check({7'h0, rdy_oe}, 8'h00, "pin released in interpolated mode");
    wr(align_pkg::ADDR_RATE, 8'h03);
    #1;
    fork
      host_model_inst.send_pulse();
      wait_strobe(n);
    join
    check_count(n, 24, 28, "pulse to strobe delay");
    $display("test interpolated alignment done");
    interp = 1'b0;
    wr(align_pkg::ADDR_RATE, 8'h00);
    wr(align_pkg::ADDR_SYNC, 8'h05);
    repeat (1100) @(posedge clk_sys_i);
    #1;
    check({7'h0, dvalid}, 8'h00, "no external clock");
    ext_en = 1'b1;
    repeat (1100) @(posedge clk_sys_i);
    #1;
    check({7'h0, dvalid}, 8'h01, "external clock present");
    fork
      host_model_inst.send_pulse();
      begin
        wait_strobe(n);
        t0 = $realtime;
      end
    join
    check_count(n, 2, 5, "pulse to strobe in align mode");
    check({7'h0, dvalid}, 8'h01, "valid after pulse");
    wait_strobe(n);
    t1 = $realtime;
    check_count(int'((t1 - t0) / 5.0), 12500, 12500, "period after alignment");
    $display("test external clock done");
    report_and_stop();
  end
endmodule
`default_nettype wire
